//--- hdl/src_pkg.sv
// constants for the receive channel configuration bank
// assumes a 32-bit classic wishbone slave with byte addresses
package src_pkg;
	localparam int NUM_CH = 3;
	localparam int IDX_W = 18;
	// register indices; byte address is four times the index
	localparam logic [17:0] IDX_CFG_B = 18'h30013;
	localparam logic [17:0] IDX_CFG_C = 18'h30023;
	localparam logic [17:0] IDX_CFG_D = 18'h30033;
	localparam logic [17:0] IDX_IRQ_STATUS = 18'h30040;
	localparam logic [17:0] IDX_IRQ_MASK = 18'h30041;
	// configuration field positions
	localparam int BIT_HALF_RATE = 0;
	localparam int BIT_PWRDN = 1;
	localparam int BIT_SD_OVR = 2;
	localparam int BIT_DEC_EN = 3;
	localparam int BIT_LINK_EN = 4;
	localparam logic [7:0] CFG_RESET = 8'h04;
	localparam logic [7:0] CFG_WR_MASK = 8'h1F;
	localparam logic [2:0] MASK_RESET = 3'h0;
	// byte clock periods in system clock cycles
	localparam int NORM_PERIOD = 2;
	localparam int HALF_PERIOD = 2 * NORM_PERIOD;
	localparam int CNT_W = 3;
endpackage

//--- hdl/src_rx_cfg.sv
// three receive channel configuration registers with alarm interrupt
// assumes energy detect inputs arrive asynchronously from the receiver
// Contract
// - half rate bit halves channel byte clocks
// - override masks detector, inhibits auto powerdown and alarm
// - override bit resets to one
// - decoder bit selects decode or bypass path
// - link bit enables link machine, resets zero; code gates link_fsm_enable_o off while the powerdown bit is set
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module src_rx_cfg
	import src_pkg::*;
#(
	parameter int ADR_W = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NUM_CH-1:0] energy_detect_i,
	output logic [NUM_CH-1:0][1:0] rx_byte_clock_o,
	output logic [NUM_CH-1:0] rx_power_down_o,
	output logic [NUM_CH-1:0] rx_decoder_enable_o,
	output logic [NUM_CH-1:0] link_fsm_enable_o,
	output logic [NUM_CH-1:0] rx_auto_pwrdn_o,
	output logic [NUM_CH-1:0] loss_of_signal_alarm_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic [2:0] cfg_hit(input logic [IDX_W-1:0] idx);
		cfg_hit = {idx == IDX_CFG_D, idx == IDX_CFG_C, idx == IDX_CFG_B};
	endfunction

	logic [IDX_W-1:0] idx;
	logic req;
	logic [2:0] hit_cfg;
	logic hit_sts;
	logic hit_msk;

	assign idx = wb_adr_i[ADR_W-1:2];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit_cfg = cfg_hit(idx);
	assign hit_sts = idx == IDX_IRQ_STATUS;
	assign hit_msk = idx == IDX_IRQ_MASK;

	////////////////////////////////////////////////////////////////
	// energy detect synchroniser

	logic [NUM_CH-1:0] ed_meta_reg;
	logic [NUM_CH-1:0] ed_sync_reg;

	always_ff @(posedge clk_i) begin
		ed_meta_reg <= energy_detect_i;
		ed_sync_reg <= ed_meta_reg;
	end

	////////////////////////////////////////////////////////////////
	// registers and bus

	logic [NUM_CH-1:0][7:0] cfg_reg, cfg_next;
	logic [NUM_CH-1:0] sts_reg, sts_next;
	logic [NUM_CH-1:0] msk_reg, msk_next;
	logic [NUM_CH-1:0] alarm_q_reg, alarm_q_next;
	logic ack_reg, ack_next;
	logic [31:0] rdat_reg, rdat_next;
	logic [NUM_CH-1:0] ovr;
	logic [NUM_CH-1:0] alarm;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ovr[c] = cfg_reg[c][BIT_SD_OVR];
		end
		// detector output masked by the override bit
		alarm = ~ed_sync_reg & ~ovr;
	end

	always_comb begin
		cfg_next = cfg_reg;
		msk_next = msk_reg;
		alarm_q_next = alarm;
		ack_next = req;
		rdat_next = 32'h0000_0000;
		sts_next = sts_reg;
		if (req && wb_we_i && wb_sel_i[0]) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (hit_cfg[c]) begin
					cfg_next[c] = wb_dat_i[7:0] & CFG_WR_MASK;
				end
			end
			if (hit_msk) begin
				msk_next = wb_dat_i[NUM_CH-1:0];
			end
			if (hit_sts) begin
				sts_next = sts_reg & ~wb_dat_i[NUM_CH-1:0];
			end
		end
		// set applied after clear so a same-cycle event survives
		sts_next = sts_next | (alarm & ~alarm_q_reg);
		if (req && !wb_we_i) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (hit_cfg[c]) begin
					rdat_next[7:0] = cfg_reg[c];
				end
			end
			if (hit_sts) begin
				rdat_next[NUM_CH-1:0] = sts_reg;
			end
			if (hit_msk) begin
				rdat_next[NUM_CH-1:0] = msk_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int c = 0; c < NUM_CH; c++) begin
				cfg_reg[c] <= CFG_RESET;
			end
			sts_reg <= '0;
			msk_reg <= MASK_RESET;
			alarm_q_reg <= '0;
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0000_0000;
		end else begin
			cfg_reg <= cfg_next;
			sts_reg <= sts_next;
			msk_reg <= msk_next;
			alarm_q_reg <= alarm_q_next;
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign irq_o = |(sts_reg & msk_reg);

	////////////////////////////////////////////////////////////////
	// byte clock enables, one divider per channel

	logic [NUM_CH-1:0][CNT_W-1:0] cnt_reg, cnt_next;
	logic [NUM_CH-1:0] bclk_reg, bclk_next;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			cnt_next[c] = cnt_reg[c] + 3'h1;
			bclk_next[c] = 1'b0;
			// powered-down channel gets no byte clock
			if (cfg_reg[c][BIT_PWRDN]) begin
				cnt_next[c] = '0;
			end else if (cnt_reg[c] >= (cfg_reg[c][BIT_HALF_RATE] ?
					CNT_W'(HALF_PERIOD - 1) : CNT_W'(NORM_PERIOD - 1))) begin
				cnt_next[c] = '0;
				bclk_next[c] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			bclk_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
			bclk_reg <= bclk_next;
		end
	end

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			rx_byte_clock_o[c] = {2{bclk_reg[c]}};
			rx_power_down_o[c] = cfg_reg[c][BIT_PWRDN];
			rx_decoder_enable_o[c] = cfg_reg[c][BIT_DEC_EN];
			link_fsm_enable_o[c] = cfg_reg[c][BIT_LINK_EN] & ~cfg_reg[c][BIT_PWRDN];
		end
	end

	// auto powerdown only without energy and without override
	assign rx_auto_pwrdn_o = alarm;
	assign loss_of_signal_alarm_o = alarm;

	////////////////////////////////////////////////////////////////
	// checks

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_cfg_reset: assert property (@(posedge clk_i)
		$past(rst_i) |-> (cfg_reg[0] == CFG_RESET && cfg_reg[1] == CFG_RESET && cfg_reg[2] == CFG_RESET))
		else $error("configuration not at reset value");

	a_pwrdn_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_power_down_o[0] ##1 rx_power_down_o[0]) |-> !rx_byte_clock_o[0][0])
		else $error("byte clock while powered down");

	a_normal_rate: assert property (@(posedge clk_i) disable iff (rst_i)
		(bclk_reg[0] && !cfg_reg[0][BIT_HALF_RATE] && !cfg_reg[0][BIT_PWRDN])
		|=> !bclk_reg[0] ##1 (bclk_reg[0] || cfg_reg[0][BIT_PWRDN] || $past(cfg_reg[0][BIT_PWRDN]) ||
		cfg_reg[0][BIT_HALF_RATE]))
		else $error("normal rate byte clock period wrong");

	a_half_rate: assert property (@(posedge clk_i) disable iff (rst_i)
		(bclk_reg[1] && cfg_reg[1][BIT_HALF_RATE] ##1 cfg_reg[1][BIT_HALF_RATE][*3])
		|-> $past(!bclk_reg[1], 1) && $past(!bclk_reg[1], 2))
		else $error("half rate byte clock too fast");

	a_los_masked: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(sts_reg[0]) |-> $past(!cfg_reg[0][BIT_SD_OVR]) && $past(!ed_sync_reg[0]))
		else $error("alarm raised while override set");

	sequence s_cfg_write(int bitpos);
		wb_ack_o && $past(wb_we_i && wb_sel_i[0] && hit_cfg[0] && wb_dat_i[bitpos]);
	endsequence

	a_decoder_path: assert property (@(posedge clk_i) disable iff (rst_i)
		s_cfg_write(BIT_DEC_EN) |-> rx_decoder_enable_o[0])
		else $error("decoder enable not applied");

	a_link_enable: assert property (@(posedge clk_i) disable iff (rst_i)
		(s_cfg_write(BIT_LINK_EN) and !rx_power_down_o[0]) |-> link_fsm_enable_o[0])
		else $error("link machine enable not applied");
endmodule

//--- verification/src_rx_cfg_bench.sv
// bench for the receive channel configuration bank
// assumes the package is compiled first; drives wishbone and energy inputs
`timescale 1ns/1ps
module src_rx_cfg_bench
	import src_pkg::*;
;
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic cyc = 1'b0;
logic stb = 1'b0;
logic we = 1'b0;
logic [19:0] adr = 20'h0;
logic [31:0] wd = 32'h0;
logic [31:0] dat;
logic ack;
logic [2:0] en_det = 3'h0;
logic [NUM_CH-1:0][1:0] bclk;
logic [NUM_CH-1:0] pd, dec, lnk, apd, los;
logic irq;
int num_errors = 0;
int compares = 0;
int cnt;
src_rx_cfg dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
	.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .energy_detect_i(en_det),
	.rx_byte_clock_o(bclk), .rx_power_down_o(pd), .rx_decoder_enable_o(dec), .link_fsm_enable_o(lnk),
	.rx_auto_pwrdn_o(apd), .loss_of_signal_alarm_o(los), .irq_o(irq));
initial begin
	forever #10 clk_i = ~clk_i;
end
////////////////////////////////////////////////////////////////
task automatic conclude();
	$display("errors %0d compares %0d", num_errors, compares);
	if (num_errors == 0 && compares > 0) begin
		$display("All tests passed");
	end else begin
		$display("Some tests failed");
	end
	$finish;
endtask
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	compares++;
	if (seen !== exp) begin
		num_errors++;
		$display("unexpected at %0t: got %h want %h", $time, seen, exp);
	end
endtask
// one classic cycle; no ack within the bound ends the run
task automatic bus(input logic w, input logic [17:0] idx, input logic [7:0] d, output logic [31:0] r);
	int n;
	n = 0;
	cyc <= 1'b1;
	stb <= 1'b1;
	we <= w;
	adr <= {idx, 2'b00};
	wd <= {24'h0, d};
	do begin
		@(posedge clk_i);
		n++;
	end while (ack !== 1'b1 && n < 20);
	if (ack !== 1'b1) begin
		num_errors++;
		conclude();
	end
	r = dat;
	cyc <= 1'b0;
	stb <= 1'b0;
	we <= 1'b0;
	@(posedge clk_i);
endtask
task automatic wr(input logic [17:0] idx, input logic [7:0] d);
	logic [31:0] r;
	bus(1'b1, idx, d, r);
endtask
task automatic rd(input logic [17:0] idx, input logic [31:0] exp);
	logic [31:0] r;
	bus(1'b0, idx, 8'h0, r);
	check(r, exp);
endtask
// counts byte clock pulses; both clocks of a channel must match
task automatic pulses(input int ch, input int n);
	cnt = 0;
	repeat (n) begin
		@(posedge clk_i);
		if (bclk[ch][0] === 1'b1) cnt++;
		check({31'h0, bclk[ch][1]}, {31'h0, bclk[ch][0]});
	end
endtask
////////////////////////////////////////////////////////////////
initial begin
	repeat (20) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	rd(IDX_CFG_B, 32'h4);
	rd(IDX_CFG_C, 32'h4);
	rd(IDX_CFG_D, 32'h4);
	check({20'h0, los, dec, lnk, pd}, 32'h0);
	check({31'h0, irq}, 32'h0);
	// unmapped place reads zero
	rd(18'h30050, 32'h0);
	wr(IDX_IRQ_MASK, 8'h01);
	// clearing the override exposes missing energy on channel b
	wr(IDX_CFG_B, 8'hF8);
	rd(IDX_CFG_B, 32'h18);
	check({29'h0, dec}, 32'h1);
	check({29'h0, lnk}, 32'h1);
	check({26'h0, los, apd}, 32'h9);
	repeat (3) @(posedge clk_i);
	rd(IDX_IRQ_STATUS, 32'h1);
	check({31'h0, irq}, 32'h1);
	wr(IDX_IRQ_STATUS, 8'h01);
	rd(IDX_IRQ_STATUS, 32'h0);
	check({31'h0, irq}, 32'h0);
	// masked event still latches but stays quiet
	wr(IDX_IRQ_MASK, 8'h00);
	en_det <= 3'h1;
	repeat (4) @(posedge clk_i);
	check({31'h0, los[0]}, 32'h0);
	en_det <= 3'h0;
	repeat (5) @(posedge clk_i);
	rd(IDX_IRQ_STATUS, 32'h1);
	check({31'h0, irq}, 32'h0);
	// power-down stops clocks and link machine
	wr(IDX_CFG_B, 8'h1A);
	check({29'h0, pd}, 32'h1);
	check({29'h0, lnk}, 32'h0);
	pulses(0, 16);
	check(cnt, 32'h0);
	pulses(1, 16);
	check(cnt, 32'h8);
	wr(IDX_CFG_C, 8'h05);
	repeat (4) @(posedge clk_i);
	pulses(1, 16);
	check(cnt, 32'h4);
	// channel d: only the five control bits are writable
	wr(IDX_CFG_D, 8'hFF);
	rd(IDX_CFG_D, 32'h1F);
	check({29'h0, pd}, 32'h5);
	check({29'h0, lnk}, 32'h0);
	check({29'h0, los[2:1], 1'b0}, 32'h0);
	// reset in mid-run brings every channel back to its default
	rst_i <= 1'b1;
	repeat (2) @(posedge clk_i);
	rst_i <= 1'b0;
	@(posedge clk_i);
	rd(IDX_CFG_B, 32'h4);
	rd(IDX_CFG_C, 32'h4);
	rd(IDX_CFG_D, 32'h4);
	check({20'h0, los, dec, lnk, pd}, 32'h0);
	rd(IDX_IRQ_STATUS, 32'h0);
	conclude();
end
endmodule
